// file: common/ipc_consts.vh
// constants for the port e/f pull control register bank
//
// What this block does
// - port e pin pull-up on when its up bit set, down clear, apply set
// - port e pin pull-down on when its down bit and apply bit set
// - port f pin pull-up on when its up bit set, down clear, apply set
// - port f pin pull-down on when its down bit and apply bit set
// - all four registers clear on device reset, kept across standby exit
// - power block soft reset leaves all four registers unchanged
// - accesses add wait cycles: three for a write, two for a read
// - port e bits exist only on the largest variant, else reserved
// - port f bits 13:3 exist only on largest variant, else bits 2:0
`ifndef IPC_CONSTS_VH
`define IPC_CONSTS_VH
// ****************************************
// register offsets
// ****************************************
`define IPC_OFS_E_UP     8'h40
`define IPC_OFS_E_DOWN   8'h44
`define IPC_OFS_F_UP     8'h48
`define IPC_OFS_F_DOWN   8'h4c
// ****************************************
// reset values and field widths
// ****************************************
`define IPC_RST_VAL      32'h00000000
`define IPC_E_PINS       16
`define IPC_F_PINS       14
`define IPC_F_SMALL_PINS 3
// ****************************************
// extra bus wait cycles
// ****************************************
`define IPC_WR_WAIT      2'h3
`define IPC_RD_WAIT      2'h2
`endif

// file: hw/ipc_pull_bank.v
// port e/f pull control register bank with waited register port
`timescale 1ns/10ps
`include "ipc_consts.vh"
module ipc_pull_bank #(
	parameter FULL_VARIANT = 1
) (
	input  wire        I_CLK_SYS,
	input  wire        I_SRST,
	input  wire        i_sel,
	input  wire        i_write,
	input  wire [7:0]  i_addr,
	input  wire [31:0] i_wdata,
	input  wire        i_global_pull_apply,
	output wire        o_ready,
	output reg  [31:0] o_rdata,
	output wire        o_error,
	output wire [15:0] o_port_e_pull_up,
	output wire [15:0] o_port_e_pull_down,
	output wire [13:0] o_port_f_pull_up,
	output wire [13:0] o_port_f_pull_down
);
	// ****************************************
	// implemented bit masks
	// ****************************************
	localparam [15:0] E_MASK = (FULL_VARIANT != 0) ? 16'hffff : 16'h0000;
	localparam [13:0] F_MASK = (FULL_VARIANT != 0) ? 14'h3fff : 14'h0007;

	// ****************************************
	// sequencer states, one-hot
	// ****************************************
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_WAIT = 3'h2;
	localparam [2:0] ST_DONE = 3'h4;

	// ****************************************
	// state and storage
	// ****************************************
	reg [2:0]  state_ff;
	reg [2:0]  nxt_state;
	reg [1:0]  wait_ff;
	reg [1:0]  nxt_wait;
	reg [15:0] e_up_ff;
	reg [15:0] e_down_ff;
	reg [13:0] f_up_ff;
	reg [13:0] f_down_ff;
	reg        hit;
	reg [31:0] rd_mux;
	reg [15:0] nxt_e_up;
	reg [15:0] nxt_e_down;
	reg [13:0] nxt_f_up;
	reg [13:0] nxt_f_down;
	reg [31:0] nxt_rdata;

	wire       last_wait;
	wire       wr_commit;
	wire       rd_commit;
	wire       wr_e_up;
	wire       wr_e_down;
	wire       wr_f_up;
	wire       wr_f_down;

	// ****************************************
	// address decode and read mux
	// ****************************************
	always @* begin
		hit    = 1'b1;
		rd_mux = `IPC_RST_VAL;
		case (i_addr)
			`IPC_OFS_E_UP:   rd_mux = {16'h0000, e_up_ff};
			`IPC_OFS_E_DOWN: rd_mux = {16'h0000, e_down_ff};
			`IPC_OFS_F_UP:   rd_mux = {18'h0, f_up_ff};
			`IPC_OFS_F_DOWN: rd_mux = {18'h0, f_down_ff};
			default:         hit = 1'b0;
		endcase
	end

	// ****************************************
	// access sequencer: 1 setup cycle plus extra waits
	// ****************************************
	always @* begin
		nxt_state = state_ff;
		nxt_wait  = wait_ff;
		case (state_ff)
			ST_IDLE: begin
				if (i_sel) begin
					nxt_state = ST_WAIT;
					nxt_wait  = i_write ? `IPC_WR_WAIT : `IPC_RD_WAIT;
				end
			end
			ST_WAIT: begin
				if (wait_ff == 2'h1)
					nxt_state = ST_DONE;
				nxt_wait = wait_ff - 2'h1;
			end
			ST_DONE: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	// ****************************************
	// handshake outputs
	// ****************************************
	// ready comes from the state register only, so bus inputs cannot glitch it
	assign o_ready = (state_ff == ST_DONE);
	assign o_error = o_ready & ~hit;

	// ****************************************
	// commit strobes
	// ****************************************
	// address and direction are sampled in the last wait cycle, so they must stay held
	assign last_wait = (state_ff == ST_WAIT) && (wait_ff == 2'h1);
	assign wr_commit = last_wait & i_write;
	assign rd_commit = last_wait & ~i_write;
	// a write to an unmapped offset raises no strobe and is dropped
	assign wr_e_up   = wr_commit & (i_addr == `IPC_OFS_E_UP);
	assign wr_e_down = wr_commit & (i_addr == `IPC_OFS_E_DOWN);
	assign wr_f_up   = wr_commit & (i_addr == `IPC_OFS_F_UP);
	assign wr_f_down = wr_commit & (i_addr == `IPC_OFS_F_DOWN);

	// ****************************************
	// next enable values
	// ****************************************
	always @* begin
		nxt_e_up   = e_up_ff;
		nxt_e_down = e_down_ff;
		nxt_f_up   = f_up_ff;
		nxt_f_down = f_down_ff;
		if (wr_e_up)
			nxt_e_up = i_wdata[15:0] & E_MASK;
		if (wr_e_down)
			nxt_e_down = i_wdata[15:0] & E_MASK;
		if (wr_f_up)
			nxt_f_up = i_wdata[13:0] & F_MASK;
		if (wr_f_down)
			nxt_f_down = i_wdata[13:0] & F_MASK;
	end

	// ****************************************
	// next read word
	// ****************************************
	always @* begin
		nxt_rdata = o_rdata;
		if (rd_commit)
			nxt_rdata = rd_mux;
	end

	// ****************************************
	// sequencer registers
	// ****************************************
	// done always returns to idle, so a request held one cycle past ready is not taken twice; one still held in idle starts a new access
	always @(posedge I_CLK_SYS) begin
		if (I_SRST) begin
			state_ff <= ST_IDLE;
			wait_ff  <= 2'h0;
		end else begin
			state_ff <= nxt_state;
			wait_ff  <= nxt_wait;
		end
	end

	// ****************************************
	// read data register
	// ****************************************
	// holds the last read word until the next read completes
	always @(posedge I_CLK_SYS) begin
		if (I_SRST)
			o_rdata <= `IPC_RST_VAL;
		else
			o_rdata <= nxt_rdata;
	end

	// ****************************************
	// pull enable registers
	// ****************************************
	// only the device reset clears; no standby or soft reset input exists
	always @(posedge I_CLK_SYS) begin
		if (I_SRST)
			e_up_ff <= 16'h0000;
		else
			e_up_ff <= nxt_e_up;
	end

	always @(posedge I_CLK_SYS) begin
		if (I_SRST)
			e_down_ff <= 16'h0000;
		else
			e_down_ff <= nxt_e_down;
	end

	always @(posedge I_CLK_SYS) begin
		if (I_SRST)
			f_up_ff <= 14'h0000;
		else
			f_up_ff <= nxt_f_up;
	end

	always @(posedge I_CLK_SYS) begin
		if (I_SRST)
			f_down_ff <= 14'h0000;
		else
			f_down_ff <= nxt_f_down;
	end

	// ****************************************
	// pull gating
	// ****************************************
	ipc_pull_gate #(.PINS(`IPC_E_PINS)) u_gate_e (
		.i_up_en     (e_up_ff),
		.i_down_en   (e_down_ff),
		.i_apply     (i_global_pull_apply),
		.o_pull_up   (o_port_e_pull_up),
		.o_pull_down (o_port_e_pull_down)
	);

	ipc_pull_gate #(.PINS(`IPC_F_PINS)) u_gate_f (
		.i_up_en     (f_up_ff),
		.i_down_en   (f_down_ff),
		.i_apply     (i_global_pull_apply),
		.o_pull_up   (o_port_f_pull_up),
		.o_pull_down (o_port_f_pull_down)
	);
endmodule // ipc_pull_bank

// file: hw/ipc_pull_gate.v
// per-pin pull-up / pull-down gating for one port
`timescale 1ns/10ps
module ipc_pull_gate #(
	parameter PINS = 16
) (
	input  wire [PINS-1:0] i_up_en,
	input  wire [PINS-1:0] i_down_en,
	input  wire            i_apply,
	output wire [PINS-1:0] o_pull_up,
	output wire [PINS-1:0] o_pull_down
);
	genvar g;
	generate
		for (g = 0; g < PINS; g = g + 1) begin : g_pin
			// down wins over up when both are set
			assign o_pull_up[g]   = i_apply & i_up_en[g] & ~i_down_en[g];
			assign o_pull_down[g] = i_apply & i_down_en[g];
		end
	endgenerate
endmodule // ipc_pull_gate

// file: sim/ipc_pull_bank_checker.sv
// checker for the pull control bank
`timescale 1ns/10ps
module ipc_chk(
	input wire        I_CLK_SYS,I_SRST,i_sel,i_write,i_global_pull_apply,o_ready,o_error,
	input wire [7:0]  i_addr,
	input wire [31:0] i_wdata,o_rdata,
	input wire [15:0] o_port_e_pull_up,o_port_e_pull_down,
	input wire [13:0] o_port_f_pull_up,o_port_f_pull_down);
default clocking dc @(posedge I_CLK_SYS); endclocking
default disable iff (I_SRST);
wire ap = i_global_pull_apply;
wire [59:0] pulls = {o_port_e_pull_up,o_port_e_pull_down,o_port_f_pull_up,o_port_f_pull_down};
sequence s_wr; ##1 !o_ready[*3] ##1 o_ready; endsequence
sequence s_rd; ##1 !o_ready[*2] ##1 o_ready; endsequence
chk_wr_wait: assert property ($rose(i_sel) && i_write |-> s_wr) else $error("wr wait");
chk_rd_wait: assert property ($rose(i_sel) && !i_write |-> s_rd) else $error("rd wait");
chk_rdy_pulse: assert property (o_ready |=> !o_ready) else $error("ready");
chk_e_excl: assert property (!(|(o_port_e_pull_up & o_port_e_pull_down))) else $error("e");
chk_f_excl: assert property (!(|(o_port_f_pull_up & o_port_f_pull_down))) else $error("f");
chk_e_apply: assert property (!ap |-> !(|{o_port_e_pull_up,o_port_e_pull_down}))
	else $error("e apply");
chk_f_apply: assert property (!ap |-> !(|{o_port_f_pull_up,o_port_f_pull_down}))
	else $error("f apply");
chk_err_read: assert property (o_ready && o_error && !i_write |-> o_rdata == 0)
	else $error("err read");
// pulls move only through a write, the apply level or a device reset
chk_pull_hold: assert property (!i_sel && !$past(i_sel) && !$past(I_SRST) && $stable(ap)
	|-> $stable(pulls)) else $error("hold");
chk_rst_clear: assert property ($past(I_SRST) |-> !(|pulls) && o_rdata == 0 && !o_ready)
	else $error("reset clear");
endmodule // ipc_chk
bind ipc_pull_bank ipc_chk u_chk(.*);

// file: sim/test_ipc_pull_bank.sv
// self-checking bench for the pull control bank
`timescale 1ns/10ps
module test_ipc_pull_bank;
logic clk=0,rst=1,sel=0,wr=0,ap=0;
logic [7:0] ad=0;
logic [31:0] wd=0,m[4];
wire rdy,er;
wire [31:0] rd;
wire [15:0] eu,ed;
wire [13:0] fu,fd;
integer n_fail=0,compares=0,i;
ipc_pull_bank dut(.I_CLK_SYS(clk),.I_SRST(rst),.i_sel(sel),.i_write(wr),.i_addr(ad),
	.i_wdata(wd),.i_global_pull_apply(ap),.o_ready(rdy),.o_rdata(rd),.o_error(er),
	.o_port_e_pull_up(eu),.o_port_e_pull_down(ed),.o_port_f_pull_up(fu),.o_port_f_pull_down(fd));
always #5 clk = ~clk;
task chk(input string s, input logic [31:0] e,v);
	compares++;
	if (v !== e) begin n_fail++; $display("[FAIL] %s exp %h got %h",s,e,v); end
endtask
task conclude;
	$display("compares %0d n_fail %0d",compares,n_fail);
	if (n_fail == 0 && compares > 0) $display("Simulation passed");
	else $display("Simulation failed");
	$finish;
endtask
task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
	integer k,n;
	logic ok;
	logic [31:0] mk;
	k = (a-8'h40)>>2;
	ok = a[1:0] == 0 && a >= 8'h40 && a <= 8'h4c;
	mk = k < 2 ? 32'hffff : 32'h3fff;
	n = 0;
	@(negedge clk); sel = 1; wr = w; ad = a; wd = d & mk;
	@(posedge clk); #1;
	while (rdy !== 1'b1 && n < 9) begin @(posedge clk); #1; n++; end
	chk("wait",w ? 3 : 2,n);
	chk("err",!ok,er);
	if (!w) chk("rdata",ok ? m[k] : 0,rd);
	else if (ok) m[k] = d & mk;
	@(posedge clk); // hold the request through the edge that samples ready
	@(negedge clk); sel = 0;
endtask
task pulls;
	logic [31:0] x;
	x = {32{ap}};
	chk("eu",m[0] & ~m[1] & x,eu);
	chk("ed",m[1] & x,ed);
	chk("fu",m[2] & ~m[3] & x,fu);
	chk("fd",m[3] & x,fd);
endtask
initial begin
	m = '{default:0};
	i = $urandom(32'h4cf71e40);
	repeat (8) @(posedge clk);
	@(negedge clk); rst = 0;
	for (i = 0; i < 4; i++) acc(0,8'h40+4*i,0);
	// 0x50 is the unmapped slot
	for (i = 0; i < 40; i++) begin
		@(negedge clk); ap = $urandom;
		acc($urandom,$urandom%5*4+8'h40,$urandom);
		pulls;
	end
	@(negedge clk); rst = 1;
	@(negedge clk); rst = 0; m = '{default:0};
	for (i = 0; i < 4; i++) acc(0,8'h40+4*i,0);
	pulls;
	conclude;
end
initial begin #20000; n_fail++; conclude; end
endmodule // test_ipc_pull_bank
